// File: cmdec_top.v
// Overview of operation
// RULE1 - zero command word is idle; repeat identical commands with idle in between
// RULE2 - every command bit acts only on its clear-to-set transition, host bit excepted
// RULE3 - held host bit reissues when letters or a data word changed
// RULE4 - rising bit 1 energizes the motor
// RULE5 - rising bit 2 disengages the motor
// RULE6 - rising bit 3 relative move, bit 4 absolute move, using elements 4 to 7
// RULE7 - controller loads velocity, accel, decel, distance into elements 4 to 7 first
// RULE8 - rising bits 5 to 9 and 11 to 13 start i/o conditioned moves
// RULE9 - controller puts i/o point in data one, second point in data two
// RULE10 - rising bit 14 is a crash stop at maximum acceleration
// RULE11 - rising bit 15 is a normal stop ramping with configured deceleration
// RULE12 - rising bit 16 starts a jog using elements 1, 2 and 3
// RULE13 - jog speed is signed; negative means counter-clockwise
// RULE14 - rising bit 17 applies new jog speed immediately while moving
// RULE15 - jog accel and decel change only at standstill
// RULE16 - controller puts two ascii letters in low 16 bits of element 9
// RULE17 - bit 18 set runs the host command from elements 9, 10, 11
// RULE18 - rising bit 19 runs the stored segment numbered in element 10
// RULE19 - rising bit 10 starts the speed change move
// RULE20 - rising bit 20 requests an alarm reset
// RULE21 - rising bit 21 applies current from element 8, only where supported
// RULE22 - i/o code: upper byte condition, lower byte 0xb0 plus point
// RULE23 - edges found by comparing each command word with the previous one
// RULE24 - bit 0 and bits 22 to 31 are ignored
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "cmdec_regs.vh"

module cmdec_top #(
	parameter HAS_CURRENT_CMD = 1
) (
	input wire core_clk,
	input wire rst_n,
	input wire ce,
	input wire [4:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire motor_moving,
	output reg motor_enabled,
	output wire enable_pulse,
	output wire disable_pulse,
	output wire relative_move,
	output wire absolute_position_move,
	output wire sensor_move,
	output wire double_sensor_move,
	output wire safety_distance_move,
	output wire mask_distance_move,
	output wire output_setting_move,
	output wire speed_change_move,
	output wire seek_origin_move,
	output wire origin_move_b,
	output wire move_variant_e,
	output wire crash_stop,
	output wire normal_ramp_stop,
	output wire jog_start,
	output wire jog_speed_update,
	output wire stored_segment_run,
	output wire fault_reset_request,
	output wire current_demand,
	output reg host_cmd_pulse,
	output reg [31:0] move_vel,
	output reg [31:0] move_acc,
	output reg [31:0] move_dec,
	output reg [31:0] move_dist,
	output reg [31:0] jog_speed,
	output reg jog_ccw,
	output reg [31:0] jog_acc,
	output reg [31:0] jog_dec,
	output reg [31:0] current_value,
	output reg [15:0] host_letters,
	output reg [31:0] host_data1,
	output reg [31:0] host_data2,
	output reg [31:0] segment_num,
	output reg [1:0] io1_cond,
	output reg [3:0] io1_point,
	output reg io1_valid,
	output reg [1:0] io2_cond,
	output reg [3:0] io2_point,
	output reg io2_valid
);
	reg [31:0] elem_q [0:11];
	reg [31:0] cmd_prev_q;
	reg [21:0] act_q;
	reg [15:0] last_letters_q;
	reg [31:0] last_d1_q;
	reg [31:0] last_d2_q;
	wire cmd_wr;
	wire [31:0] cmd_used;
	wire [31:0] rise;
	wire host_changed;
	wire host_fire;
	wire any_move;
	wire [1:0] dec1_cond;
	wire [3:0] dec1_point;
	wire dec1_valid;
	wire [1:0] dec2_cond;
	wire [3:0] dec2_point;
	wire dec2_valid;
	integer i;

	assign cmd_wr = ce && reg_wr && reg_addr == `CMDEC_EL_CMD;
	assign cmd_used = reg_wdata & `CMDEC_USED_MASK; // RULE24
	// a zero word clears the history, so the next identical command rises again
	assign rise = cmd_wr ? (cmd_used & ~cmd_prev_q) : 32'h00000000; // RULE23 RULE1
	assign host_changed = elem_q[9][15:0] != last_letters_q ||
		elem_q[10] != last_d1_q || elem_q[11] != last_d2_q; // RULE3
	assign host_fire = cmd_wr && cmd_used[`CMDEC_B_HOST] &&
		(!cmd_prev_q[`CMDEC_B_HOST] || host_changed); // RULE17 RULE3
	assign any_move = rise[`CMDEC_B_REL] || rise[`CMDEC_B_ABS] ||
		rise[`CMDEC_B_SPDCHG] || (|rise[`CMDEC_B_VARE:`CMDEC_B_SENSOR]);

	assign enable_pulse = act_q[`CMDEC_B_ENABLE];
	assign disable_pulse = act_q[`CMDEC_B_DISABLE];
	assign relative_move = act_q[`CMDEC_B_REL];
	assign absolute_position_move = act_q[`CMDEC_B_ABS];
	assign sensor_move = act_q[`CMDEC_B_SENSOR];
	assign double_sensor_move = act_q[`CMDEC_B_DSENSOR];
	assign safety_distance_move = act_q[`CMDEC_B_SAFETY];
	assign mask_distance_move = act_q[`CMDEC_B_MASK];
	assign output_setting_move = act_q[`CMDEC_B_OUTSET];
	assign speed_change_move = act_q[`CMDEC_B_SPDCHG];
	assign seek_origin_move = act_q[`CMDEC_B_SEEK];
	assign origin_move_b = act_q[`CMDEC_B_ORIGB];
	assign move_variant_e = act_q[`CMDEC_B_VARE];
	assign crash_stop = act_q[`CMDEC_B_CRASH];
	assign normal_ramp_stop = act_q[`CMDEC_B_RAMP];
	assign jog_start = act_q[`CMDEC_B_JOG];
	assign jog_speed_update = act_q[`CMDEC_B_JOGUPD];
	assign stored_segment_run = act_q[`CMDEC_B_SEGMENT];
	assign fault_reset_request = act_q[`CMDEC_B_FAULTRST];
	assign current_demand = act_q[`CMDEC_B_CURRENT];

	cmdec_io_decode u_dec1 (
		.code(elem_q[10][15:0]),
		.cond(dec1_cond),
		.point(dec1_point),
		.valid(dec1_valid)
	);

	cmdec_io_decode u_dec2 (
		.code(elem_q[11][15:0]),
		.cond(dec2_cond),
		.point(dec2_point),
		.valid(dec2_valid)
	);

	// one-cycle action strobes, one per command bit 1 to 21; the bit 0 and host bit 18 strobes stay low
	genvar b;
	generate
		for (b = 0; b < 22; b = b + 1) begin : g_act
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					act_q[b] <= 1'b0;
				end else if (ce) begin
					if (b == 0 || b == `CMDEC_B_HOST) begin
						act_q[b] <= 1'b0; // RULE24
					end else if (b == `CMDEC_B_CURRENT) begin
						act_q[b] <= rise[b] && HAS_CURRENT_CMD != 0; // RULE21
					end else begin
						act_q[b] <= rise[b]; // RULE2 RULE4 RULE5 RULE6 RULE8 RULE10 RULE11 RULE19 RULE20
					end
				end
			end
		end
	endgenerate

	// assembly element storage and command history
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 12; i = i + 1) begin
				elem_q[i] <= `CMDEC_RST_WORD;
			end
			cmd_prev_q <= `CMDEC_RST_WORD;
		end else if (ce && reg_wr) begin
			// reserved elements 12..15 swallow writes
			if (reg_addr < 5'h0c) begin
				elem_q[reg_addr[3:0]] <= reg_wdata;
			end
			if (reg_addr == `CMDEC_EL_CMD) begin
				cmd_prev_q <= cmd_used; // RULE23
			end
		end
	end

	// motor enable state; disable wins if both rise together for safety
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			motor_enabled <= 1'b0;
		end else if (ce) begin
			if (rise[`CMDEC_B_DISABLE]) begin
				motor_enabled <= 1'b0; // RULE5
			end else if (rise[`CMDEC_B_ENABLE]) begin
				motor_enabled <= 1'b1; // RULE4
			end
		end
	end

	// move parameters are captured with the trigger so later writes cannot disturb a move
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			move_vel <= `CMDEC_RST_WORD;
			move_acc <= `CMDEC_RST_WORD;
			move_dec <= `CMDEC_RST_WORD;
			move_dist <= `CMDEC_RST_WORD;
			io1_cond <= 2'h0;
			io1_point <= 4'h0;
			io1_valid <= 1'b0;
			io2_cond <= 2'h0;
			io2_point <= 4'h0;
			io2_valid <= 1'b0;
		end else if (ce && any_move) begin
			move_vel <= elem_q[4]; // RULE6
			move_acc <= elem_q[5];
			move_dec <= elem_q[6];
			move_dist <= elem_q[7];
			io1_cond <= dec1_cond; // RULE22
			io1_point <= dec1_point;
			io1_valid <= dec1_valid;
			// only the double sensor move takes a second point
			io2_cond <= rise[`CMDEC_B_DSENSOR] ? dec2_cond : 2'h0;
			io2_point <= rise[`CMDEC_B_DSENSOR] ? dec2_point : 4'h0;
			io2_valid <= rise[`CMDEC_B_DSENSOR] && dec2_valid;
		end
	end

	// jog speed and direction
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_speed <= `CMDEC_RST_WORD;
			jog_ccw <= 1'b0;
		end else if (ce && (rise[`CMDEC_B_JOG] || rise[`CMDEC_B_JOGUPD])) begin
			jog_speed <= elem_q[1]; // RULE12 RULE14
			jog_ccw <= elem_q[1][31]; // RULE13
		end
	end

	// ramp rates only follow the elements while the shaft is still
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_acc <= `CMDEC_RST_WORD;
			jog_dec <= `CMDEC_RST_WORD;
		end else if (ce && !motor_moving) begin
			jog_acc <= elem_q[2]; // RULE15 RULE12
			jog_dec <= elem_q[3]; // RULE15
		end
	end

	// segment number and current demand
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			segment_num <= `CMDEC_RST_WORD;
			current_value <= `CMDEC_RST_WORD;
		end else if (ce) begin
			if (rise[`CMDEC_B_SEGMENT]) begin
				segment_num <= elem_q[10]; // RULE18
			end
			if (rise[`CMDEC_B_CURRENT] && HAS_CURRENT_CMD != 0) begin
				current_value <= elem_q[8]; // RULE21
			end
		end
	end

	// host command hand-off, level held with change detection
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_cmd_pulse <= 1'b0;
			host_letters <= 16'h0000;
			host_data1 <= `CMDEC_RST_WORD;
			host_data2 <= `CMDEC_RST_WORD;
			last_letters_q <= 16'h0000;
			last_d1_q <= `CMDEC_RST_WORD;
			last_d2_q <= `CMDEC_RST_WORD;
		end else if (ce) begin
			host_cmd_pulse <= host_fire; // RULE17
			if (host_fire) begin
				host_letters <= elem_q[9][15:0]; // RULE17
				host_data1 <= elem_q[10];
				host_data2 <= elem_q[11];
				last_letters_q <= elem_q[9][15:0]; // RULE3
				last_d1_q <= elem_q[10];
				last_d2_q <= elem_q[11];
			end
		end
	end

	// read port: data valid only in the cycle after the strobe
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `CMDEC_RST_WORD;
		end else if (ce) begin
			if (!reg_rd) begin
				reg_rdata <= `CMDEC_RST_WORD;
			end else if (reg_addr < 5'h0c) begin
				reg_rdata <= elem_q[reg_addr[3:0]];
			end else if (reg_addr == `CMDEC_STATUS_ADDR) begin
				reg_rdata <= {27'h0, io2_valid, io1_valid, jog_ccw,
					motor_moving, motor_enabled};
			end else begin
				reg_rdata <= `CMDEC_RST_WORD;
			end
		end
	end
endmodule

// File: cmdec_regs.vh
`ifndef CMDEC_REGS_VH
`define CMDEC_REGS_VH

// element indices on the register port
`define CMDEC_EL_CMD 5'h00
`define CMDEC_EL_JOG_SPEED 5'h01
`define CMDEC_EL_JOG_ACC 5'h02
`define CMDEC_EL_JOG_DEC 5'h03
`define CMDEC_EL_MOVE_VEL 5'h04
`define CMDEC_EL_MOVE_ACC 5'h05
`define CMDEC_EL_MOVE_DEC 5'h06
`define CMDEC_EL_MOVE_DIST 5'h07
`define CMDEC_EL_CURRENT 5'h08
`define CMDEC_EL_LETTERS 5'h09
`define CMDEC_EL_DATA1 5'h0a
`define CMDEC_EL_DATA2 5'h0b
`define CMDEC_EL_LAST 5'h0f
`define CMDEC_STATUS_ADDR 5'h10

// command word bit positions
`define CMDEC_B_ENABLE 1
`define CMDEC_B_DISABLE 2
`define CMDEC_B_REL 3
`define CMDEC_B_ABS 4
`define CMDEC_B_SENSOR 5
`define CMDEC_B_DSENSOR 6
`define CMDEC_B_SAFETY 7
`define CMDEC_B_MASK 8
`define CMDEC_B_OUTSET 9
`define CMDEC_B_SPDCHG 10
`define CMDEC_B_SEEK 11
`define CMDEC_B_ORIGB 12
`define CMDEC_B_VARE 13
`define CMDEC_B_CRASH 14
`define CMDEC_B_RAMP 15
`define CMDEC_B_JOG 16
`define CMDEC_B_JOGUPD 17
`define CMDEC_B_HOST 18
`define CMDEC_B_SEGMENT 19
`define CMDEC_B_FAULTRST 20
`define CMDEC_B_CURRENT 21
`define CMDEC_USED_MASK 32'h003ffffe

// i/o condition code fields
`define CMDEC_IO_HIGH 8'h48
`define CMDEC_IO_LOW 8'h4c
`define CMDEC_IO_RISE 8'h52
`define CMDEC_IO_FALL 8'h46
`define CMDEC_IO_BASE 8'hb0
`define CMDEC_IO_MAXPT 8'h0c

`define CMDEC_RST_WORD 32'h00000000

`endif

// File: cmdec_io_decode.v
`timescale 1ns/1ps
`include "cmdec_regs.vh"

module cmdec_io_decode (
	input wire [15:0] code,
	output reg [1:0] cond,
	output reg [3:0] point,
	output reg valid
);
	reg [7:0] off;

	always @* begin
		off = code[7:0] - `CMDEC_IO_BASE; // RULE22
		cond = 2'h0;
		valid = 1'b1;
		case (code[15:8]) // RULE22
			`CMDEC_IO_HIGH: cond = 2'h0;
			`CMDEC_IO_LOW: cond = 2'h1;
			`CMDEC_IO_RISE: cond = 2'h2;
			`CMDEC_IO_FALL: cond = 2'h3;
			default: valid = 1'b0;
		endcase
		// point 0 is the encoder index, 1..12 the inputs
		if (code[7:0] < `CMDEC_IO_BASE || off > `CMDEC_IO_MAXPT) begin
			valid = 1'b0;
		end
		point = valid ? off[3:0] : 4'h0;
	end
endmodule

// File: cmdec_properties.sv
`timescale 1ns/1ps
`include "cmdec_regs.vh"
module cmdec_properties (
	input wire core_clk,
	input wire rst_n,
	input wire ce,
	input wire [4:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire motor_moving,
	input wire motor_enabled,
	input wire enable_pulse,
	input wire disable_pulse,
	input wire relative_move,
	input wire crash_stop,
	input wire fault_reset_request,
	input wire host_cmd_pulse,
	input wire [31:0] jog_speed,
	input wire jog_ccw,
	input wire [31:0] jog_acc
);
	reg [31:0] prev_q;
	reg [31:0] el1_q;
	wire wr0 = ce && reg_wr && reg_addr == `CMDEC_EL_CMD;
	// only element-0 writes move the history
	wire [31:0] rise = wr0 ? (reg_wdata & ~prev_q & `CMDEC_USED_MASK) : 32'h0;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 32'h0;
			el1_q <= 32'h0;
		end else begin
			if (wr0) begin
				prev_q <= reg_wdata & `CMDEC_USED_MASK;
			end
			if (ce && reg_wr && reg_addr == `CMDEC_EL_JOG_SPEED) begin
				el1_q <= reg_wdata;
			end
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_ENABLE: assert property (rise[1] && !rise[2] |=> enable_pulse && motor_enabled)
		else $error("no enable");
	AST_DISABLE: assert property (rise[2] |=> disable_pulse && !motor_enabled)
		else $error("no disable");
	AST_REL_EDGE: assert property (relative_move == $past(rise[3]))
		else $error("bad relative pulse");
	AST_CRASH: assert property (rise[14] |=> crash_stop)
		else $error("no crash stop");
	AST_ALARM: assert property (fault_reset_request == $past(rise[20]))
		else $error("bad alarm reset pulse");
	AST_HOST_RISE: assert property (wr0 && reg_wdata[18] && !prev_q[18] |=> host_cmd_pulse)
		else $error("no host pulse");
	AST_HOST_SRC: assert property (host_cmd_pulse |-> $past(wr0 && reg_wdata[18]))
		else $error("stray host pulse");
	AST_JOG_SPEED: assert property (rise[17] |=> jog_speed == el1_q && jog_ccw == el1_q[31])
		else $error("jog speed not applied");
	AST_JOG_ACC: assert property (motor_moving |=> $stable(jog_acc))
		else $error("jog accel changed in motion");
	AST_IDLE: assert property (wr0 && (reg_wdata & `CMDEC_USED_MASK) == 32'h0 |=>
		!(enable_pulse || disable_pulse || relative_move || host_cmd_pulse))
		else $error("idle word acted");
	cover property (enable_pulse);
	cover property (host_cmd_pulse);
	cover property (rise[17]);
endmodule

// File: cmdec_ctl_model.sv
`timescale 1ns/1ps
module cmdec_ctl_model (
	input wire core_clk,
	output reg [4:0] reg_addr,
	output reg [31:0] reg_wdata,
	output reg reg_wr,
	output reg reg_rd,
	input wire [31:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// a free edge before each strobe keeps one assignment per step
	task wr(input [4:0] a, input [31:0] v);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	end
	endtask
	task rd(input [4:0] a, output [31:0] v);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	end
	endtask
endmodule

// File: cmdec_bench.sv
`timescale 1ns/1ps
module cmdec_bench;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg motor_moving = 1'b0;
	reg ce = 1'b1;
	integer mismatches = 0;
	integer checks = 0;
	integer b;
	reg [31:0] q;
	wire [4:0] a;
	wire [31:0] d, rdata, mv, md, js, ja, cv, hd1, sg, ma, mdc, jd, hd2, nogc_cv;
	wire w, r, en, ccw, nogc_pulse;
	wire [21:0] act;
	wire [6:0] io1, io2;
	wire [15:0] hl;
	assign act[0] = 1'b0;
	always #5 core_clk = ~core_clk;
	cmdec_ctl_model ctl (.core_clk(core_clk), .reg_addr(a), .reg_wdata(d), .reg_wr(w),
		.reg_rd(r), .reg_rdata(rdata));
	cmdec_top uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(a), .reg_wdata(d),
		.reg_wr(w), .reg_rd(r), .reg_rdata(rdata), .motor_moving(motor_moving),
		.motor_enabled(en), .enable_pulse(act[1]), .disable_pulse(act[2]),
		.relative_move(act[3]), .absolute_position_move(act[4]), .sensor_move(act[5]),
		.double_sensor_move(act[6]), .safety_distance_move(act[7]),
		.mask_distance_move(act[8]), .output_setting_move(act[9]),
		.speed_change_move(act[10]), .seek_origin_move(act[11]), .origin_move_b(act[12]),
		.move_variant_e(act[13]), .crash_stop(act[14]), .normal_ramp_stop(act[15]),
		.jog_start(act[16]), .jog_speed_update(act[17]), .host_cmd_pulse(act[18]),
		.stored_segment_run(act[19]), .fault_reset_request(act[20]),
		.current_demand(act[21]), .move_vel(mv), .move_acc(ma), .move_dec(mdc), .move_dist(md),
		.jog_speed(js), .jog_ccw(ccw), .jog_acc(ja), .jog_dec(jd), .current_value(cv),
		.host_letters(hl), .host_data1(hd1), .host_data2(hd2), .segment_num(sg),
		.io1_cond(io1[5:4]), .io1_point(io1[3:0]), .io1_valid(io1[6]),
		.io2_cond(io2[5:4]), .io2_point(io2[3:0]), .io2_valid(io2[6]));
	// a build without current command support must ignore bit 21
	cmdec_top #(.HAS_CURRENT_CMD(0)) uut_nogc (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(a), .reg_wdata(d), .reg_wr(w), .reg_rd(r), .reg_rdata(),
		.motor_moving(motor_moving), .motor_enabled(), .enable_pulse(), .disable_pulse(),
		.relative_move(), .absolute_position_move(), .sensor_move(), .double_sensor_move(),
		.safety_distance_move(), .mask_distance_move(), .output_setting_move(),
		.speed_change_move(), .seek_origin_move(), .origin_move_b(), .move_variant_e(),
		.crash_stop(), .normal_ramp_stop(), .jog_start(), .jog_speed_update(),
		.stored_segment_run(), .fault_reset_request(), .current_demand(nogc_pulse),
		.host_cmd_pulse(), .move_vel(), .move_acc(), .move_dec(), .move_dist(), .jog_speed(),
		.jog_ccw(), .jog_acc(), .jog_dec(), .current_value(nogc_cv), .host_letters(),
		.host_data1(), .host_data2(), .segment_num(), .io1_cond(), .io1_point(), .io1_valid(),
		.io2_cond(), .io2_point(), .io2_valid());
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task t_bits;
	begin
		for (b = 1; b < 22; b = b + 1) begin
			ctl.wr(5'h00, 32'h1 << b);
			chk({10'h0, act}, 32'h1 << b);
			chk({31'h0, en}, b == 1);
			chk({31'h0, nogc_pulse}, 32'h0);
			ctl.wr(5'h00, 32'h1 << b);
			chk({10'h0, act}, 32'h0);
			ctl.wr(5'h00, 32'h0);
			chk({10'h0, act}, 32'h0);
		end
		ctl.wr(5'h00, 32'hffc00001);
		chk({10'h0, act}, 32'h0);
	end
	endtask
	task t_params;
	begin
		for (b = 4; b < 8; b = b + 1) begin
			ctl.wr(b[4:0], 32'h10 + b);
		end
		ctl.wr(5'h0a, 32'h52b3);
		ctl.wr(5'h0b, 32'h4cbc);
		ctl.wr(5'h00, 32'h48);
		chk({10'h0, act}, 32'h48);
		chk(mv, 32'h14);
		chk(md, 32'h17);
		chk(ma, 32'h15);
		chk(mdc, 32'h16);
		chk({25'h0, io1}, 32'h63);
		chk({25'h0, io2}, 32'h5c);
		ctl.wr(5'h00, 32'h0);
		ctl.rd(5'h04, q);
		chk(q, 32'h14);
		ctl.rd(5'h1f, q);
		chk(q, 32'h0);
	end
	endtask
	task t_jog;
	begin
		ctl.wr(5'h01, 32'hfffffff0);
		ctl.wr(5'h02, 32'h7);
		ctl.wr(5'h03, 32'h8);
		ctl.wr(5'h00, 32'h10000);
		chk(js, 32'hfffffff0);
		chk({31'h0, ccw}, 32'h1);
		chk(ja, 32'h7);
		chk(jd, 32'h8);
		@(posedge core_clk);
		motor_moving <= 1'b1;
		ctl.wr(5'h02, 32'h9);
		ctl.wr(5'h03, 32'ha);
		ctl.wr(5'h01, 32'h20);
		ctl.wr(5'h00, 32'h30000);
		chk({10'h0, act}, 32'h20000);
		chk(js, 32'h20);
		chk({31'h0, ccw}, 32'h0);
		chk(ja, 32'h7);
		chk(jd, 32'h8);
		@(posedge core_clk);
		motor_moving <= 1'b0;
		ctl.wr(5'h00, 32'h0);
		chk(ja, 32'h9);
		chk(jd, 32'ha);
	end
	endtask
	task t_host;
	begin
		ctl.wr(5'h09, 32'h534f);
		ctl.wr(5'h0a, 32'h4cb2);
		ctl.wr(5'h00, 32'h40000);
		chk({10'h0, act}, 32'h40000);
		chk({16'h0, hl}, 32'h534f);
		ctl.wr(5'h00, 32'h40000);
		chk({10'h0, act}, 32'h0);
		ctl.wr(5'h0a, 32'h4cb3);
		ctl.wr(5'h00, 32'h40000);
		chk({10'h0, act}, 32'h40000);
		chk(hd1, 32'h4cb3);
		chk(hd2, 32'h4cbc);
		ctl.wr(5'h0a, 32'h5);
		ctl.wr(5'h08, 32'h64);
		ctl.wr(5'h00, 32'h280000);
		chk(sg, 32'h5);
		chk(cv, 32'h64);
		chk(nogc_cv, 32'h0);
	end
	endtask
	task t_ce;
	begin
		ctl.wr(5'h00, 32'h0);
		@(posedge core_clk);
		ce <= 1'b0;
		ctl.wr(5'h00, 32'h2);
		chk({10'h0, act}, 32'h0);
		chk({31'h0, en}, 32'h0);
		@(posedge core_clk);
		ce <= 1'b1;
		ctl.wr(5'h00, 32'h2);
		chk({10'h0, act}, 32'h2);
		chk({31'h0, en}, 32'h1);
		ctl.rd(5'h10, q);
		chk(q, 32'h19);
	end
	endtask
	task report_and_stop;
	begin
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	end
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_bits;
		t_params;
		t_jog;
		t_host;
		t_ce;
		report_and_stop;
	end
endmodule
bind cmdec_top cmdec_properties chk_i (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .motor_moving(motor_moving),
	.motor_enabled(motor_enabled), .enable_pulse(enable_pulse), .disable_pulse(disable_pulse),
	.relative_move(relative_move), .crash_stop(crash_stop),
	.fault_reset_request(fault_reset_request), .host_cmd_pulse(host_cmd_pulse),
	.jog_speed(jog_speed), .jog_ccw(jog_ccw), .jog_acc(jog_acc));
